// *** core/erb_top.sv ***
/*
 * Embedded RAM block set: a small simple dual-port block, a medium and a
 * large true dual-port block, each with input registers, a bypassable output
 * register, per-port clear and a two-clock choice per register kind, except that the small block's input registers share one choice.
 * Assumes user logic on the same clock drives the port requests and the two
 * per-block clock ticks as one-cycle enables, and an APB master configures.
 */
// The APB interface to the registers and the address map are this design's own decisions.
// Functional notes
// - Small block: 576 bits, no true dual-port
// - Small write registers share one clock tick
// - Small read registers take either clock tick
// - Small block takes both clocks, enables, clear
// - Only output register bypassable; inputs always registered
// - Small and medium blocks preload from image
// - Medium block: 4,608 bits, true dual-port too
// - Medium register kinds each pick a clock
// - Large block: 589,824 bits, no ROM mode
// - Large block not preloaded; contents start undefined
// - Large block synchronous; output register bypassable
// - Large register kinds each pick a clock
// - Large ports: clock, enable, renwe, clear, address enable
// - Large port data split over eight lane groups
// - Medium and large ports controlled independently
`timescale 1ns/100ps
module erb_top (
	input wire logic clk, // System clock, 10 MHz
	input wire logic nrst, // Async reset, low
	input wire logic [erb_pkg::ERB_NBLK-1:0] blk_tick0, // First clock tick per block
	input wire logic [erb_pkg::ERB_NBLK-1:0] blk_tick1, // Second clock tick per block
	input wire erb_pkg::erb_req_t [erb_pkg::ERB_NSLOT-1:0] port_req, // Port requests
	output logic [erb_pkg::ERB_NSLOT-1:0][erb_pkg::ERB_DW_MAX-1:0] port_dout, // Port data
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [erb_pkg::ERB_PADDR_W-1:0] paddr, // APB address
	input wire logic [erb_pkg::ERB_PDATA_W-1:0] pwdata, // APB write data
	output logic [erb_pkg::ERB_PDATA_W-1:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr // APB error
);
	import erb_pkg::*;

	logic [ERB_NSLOT-1:0][ERB_CFG_W-1:0] cfg_r;
	logic [ERB_NBLK-1:0] mode_r;
	logic [ERB_NBLK-1:0] refused_r;
	logic [ERB_NSLOT-1:0] outval_w;
	logic [ERB_NSLOT-1:0] refuse_evt;
	logic [ERB_NSLOT-1:0] mem_we;
	logic [ERB_NSLOT-1:0] mem_re;
	logic [ERB_NSLOT-1:0][ERB_AW_MAX-1:0] mem_addr;
	logic [ERB_NSLOT-1:0][ERB_BE_MAX-1:0] mem_be;
	logic [ERB_NSLOT-1:0][ERB_DW_MAX-1:0] mem_din;
	logic [ERB_NSLOT-1:0][ERB_DW_MAX-1:0] mem_q;

	logic apb_setup;
	logic apb_wr;
	logic mapped;
	logic [ERB_IDX_W-1:0] reg_idx;
	logic [ERB_PDATA_W-1:0] rd_word;
	logic [ERB_PDATA_W-1:0] prdata_r;
	logic err_r;
	logic sel_cfg;
	logic sel_mode;
	logic sel_stat;

	////////////////////////////////////////////////////////////////////////
	// APB slave, zero wait states: read data and error are captured in the
	// setup phase so they stand stable through the access phase

	assign apb_setup = psel && !penable;
	assign mapped = (paddr < ERB_MAP_END) && (paddr[ERB_IDX_LO-1:0] == '0);
	assign reg_idx = paddr[ERB_IDX_LO +: ERB_IDX_W];
	assign apb_wr = psel && penable && pwrite && mapped;
	assign pready = 1'b1;
	assign pslverr = psel && penable && err_r;
	assign prdata = prdata_r;

	// One-hot register selects; an unmapped address selects nothing
	always_comb begin
		sel_cfg = 1'b0;
		sel_mode = 1'b0;
		sel_stat = 1'b0;
		if (mapped) begin
			if (paddr == ERB_MODE_OFS) begin
				sel_mode = 1'b1;
			end else if (paddr == ERB_STAT_OFS) begin
				sel_stat = 1'b1;
			end else begin
				sel_cfg = 1'b1;
			end
		end
	end

	always_comb begin
		rd_word = '0;
		if (sel_mode) begin
			rd_word[ERB_NBLK-1:0] = mode_r;
		end else if (sel_stat) begin
			rd_word[ERB_ST_OV +: ERB_NSLOT] = outval_w;
			rd_word[ERB_ST_RR +: ERB_NBLK] = refused_r;
		end else if (sel_cfg) begin
			rd_word[ERB_CFG_W-1:0] = cfg_r[reg_idx];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prdata_r <= '0;
		end else if (apb_setup) begin
			prdata_r <= mapped ? rd_word : '0;
		end
	end

	// Error decided at setup so pslverr needs no address decode later
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			err_r <= 1'b0;
		end else if (apb_setup) begin
			err_r <= !mapped;
		end
	end

	// Per-slot clock choices and bypass
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int s = 0; s < ERB_NSLOT; s++) begin
				cfg_r[s] <= ERB_CFG_RST;
			end
		end else if (apb_wr && sel_cfg) begin
			cfg_r[reg_idx] <= pwdata[ERB_CFG_W-1:0];
		end
	end

	// ROM use locks writes; the large block has no ROM bit
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			mode_r <= ERB_MODE_RST;
		end else if (apb_wr && sel_mode) begin
			mode_r <= pwdata[ERB_NBLK-1:0] & ERB_ROM_OK;
		end
	end

	// Refused-write flags, write one to clear; a new event beats the clear
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			refused_r <= '0;
		end else begin
			for (int b = 0; b < ERB_NBLK; b++) begin
				if (refuse_evt[2*b] || refuse_evt[2*b+1]) begin
					refused_r[b] <= 1'b1;
				end else if (apb_wr && sel_stat && pwdata[ERB_ST_RR+b]) begin
					refused_r[b] <= 1'b0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Port slots: input registers, access strobe, output register

	for (genvar s = 0; s < ERB_NSLOT; s++) begin : g_slot
		localparam int B = s / 2;
		// Small block: one tick choice covers a whole register group
		localparam bit SHARED = !ERB_TDP[B];
		erb_req_t req;
		logic t_ctl;
		logic t_addr;
		logic t_be;
		logic t_din;
		logic t_out;
		logic s_ctl;
		logic s_addr;
		logic s_be;
		logic s_din;
		logic go_r;
		logic wr_r;
		logic rd_r;
		logic [ERB_AW_MAX-1:0] addr_r;
		logic [ERB_BE_MAX-1:0] be_r;
		logic [ERB_DW_MAX-1:0] din_r;
		logic [ERB_DW_MAX-1:0] out_r;
		logic ov_r;
		logic oclr_n;

		assign req = port_req[s];
		assign s_ctl = cfg_r[s][ERB_CF_CTL];
		assign s_addr = SHARED ? s_ctl : cfg_r[s][ERB_CF_ADDR];
		assign s_be = SHARED ? s_ctl : cfg_r[s][ERB_CF_BE];
		assign s_din = SHARED ? s_ctl : cfg_r[s][ERB_CF_DIN];
		assign t_ctl = req.clken && (s_ctl ? blk_tick1[B] : blk_tick0[B]);
		assign t_addr = req.clken && (s_addr ? blk_tick1[B] : blk_tick0[B]);
		assign t_be = req.clken && (s_be ? blk_tick1[B] : blk_tick0[B]);
		assign t_din = req.clken && (s_din ? blk_tick1[B] : blk_tick0[B]);
		assign t_out = cfg_r[s][ERB_CF_OUT] ? blk_tick1[B] : blk_tick0[B];

		// Control register; the access runs on the cycle after the tick
		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				go_r <= 1'b0;
				wr_r <= 1'b0;
				rd_r <= 1'b0;
			end else begin
				go_r <= t_ctl;
				if (t_ctl) begin
					wr_r <= req.wren && ERB_CAN_WR[s];
					// Dual-port ports read whenever renwe is low
					rd_r <= (ERB_TDP[B] ? !req.wren : req.rden) && ERB_CAN_RD[s];
				end
			end
		end

		// Small block has no address enable: it always loads
		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				addr_r <= '0;
			end else if (t_addr && (req.addr_ena || SHARED)) begin
				addr_r <= req.addr;
			end
		end

		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				be_r <= '0;
			end else if (t_be) begin
				be_r <= req.be;
			end
		end

		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) begin
				din_r <= '0;
			end else if (t_din) begin
				din_r <= req.din;
			end
		end

		assign mem_we[s] = go_r && wr_r && !mode_r[B];
		assign mem_re[s] = go_r && rd_r;
		assign refuse_evt[s] = go_r && wr_r && mode_r[B];
		assign mem_addr[s] = addr_r;
		assign mem_be[s] = be_r;
		assign mem_din[s] = din_r;

		// Port clear reaches only this output register and its valid bit, never the array
		assign oclr_n = nrst && !req.aclr;

		always_ff @(posedge clk or negedge oclr_n) begin
			if (!oclr_n) begin
				out_r <= '0;
			end else if (t_out) begin
				out_r <= mem_q[s];
			end
		end

		// Status valid bit shares the clear with the output register
		always_ff @(posedge clk or negedge oclr_n) begin
			if (!oclr_n) begin
				ov_r <= 1'b0;
			end else if (t_out) begin
				ov_r <= 1'b1;
			end
		end

		assign outval_w[s] = ov_r;
		// Bypass trades a cycle of latency for a clear that cannot act
		assign port_dout[s] = cfg_r[s][ERB_CF_BYP] ? mem_q[s] : out_r;
	end

	////////////////////////////////////////////////////////////////////////
	// Storage arrays, one per block size

	for (genvar b = 0; b < ERB_NBLK; b++) begin : g_blk
		localparam int AW = ERB_AW[b];
		localparam int BW = ERB_BE[b];
		localparam int DW = BW * ERB_BYTE_W;
		logic [DW-1:0] qa;
		logic [DW-1:0] qb;

		erb_mem #(
			.AW(AW),
			.BW(BW),
			.INIT_EN(ERB_INIT_OK[b]),
			.INIT_IMG(ERB_INIT_IMG)
		) u_mem (
			.clk(clk),
			.nrst(nrst),
			.a_we(mem_we[2*b]),
			.a_re(mem_re[2*b]),
			.a_addr(mem_addr[2*b][AW-1:0]),
			.a_be(mem_be[2*b][BW-1:0]),
			.a_din(mem_din[2*b][DW-1:0]),
			.a_q(qa),
			.b_we(mem_we[2*b+1]),
			.b_re(mem_re[2*b+1]),
			.b_addr(mem_addr[2*b+1][AW-1:0]),
			.b_be(mem_be[2*b+1][BW-1:0]),
			.b_din(mem_din[2*b+1][DW-1:0]),
			.b_q(qb)
		);

		// Capacity per block: 576, 4,608 and 589,824 bits
		assign mem_q[2*b] = ERB_DW_MAX'(qa);
		assign mem_q[2*b+1] = ERB_DW_MAX'(qb);
	end
endmodule

// *** core/erb_pkg.sv ***
/*
 * Shared constants and types for the embedded RAM block set: block geometry,
 * register map, field positions and the per-port request carrier.
 * Assumes a single 10 MHz system clock; nothing else.
 */
package erb_pkg;
	// Three block sizes: small, medium, large
	localparam int ERB_NBLK = 3;
	localparam int ERB_NSLOT = 2 * ERB_NBLK;
	localparam int ERB_BYTE_W = 9;
	localparam int ERB_AW_MAX = 13;
	localparam int ERB_BE_MAX = 8;
	localparam int ERB_DW_MAX = ERB_BE_MAX * ERB_BYTE_W;
	localparam int ERB_AW [ERB_NBLK] = '{5, 7, 13};
	localparam int ERB_BE [ERB_NBLK] = '{2, 4, 8};
	// Storage bits per block, parity included
	localparam int ERB_BITS [ERB_NBLK] = '{576, 4608, 589824};
	// Per block: preload allowed, ROM use allowed, true dual-port
	localparam logic [ERB_NBLK-1:0] ERB_INIT_OK = 3'h3;
	localparam logic [ERB_NBLK-1:0] ERB_ROM_OK = 3'h3;
	localparam logic [ERB_NBLK-1:0] ERB_TDP = 3'h6;
	// Slot 0 small write port, slot 1 small read port, then A/B pairs
	localparam logic [ERB_NSLOT-1:0] ERB_CAN_WR = 6'h3D;
	localparam logic [ERB_NSLOT-1:0] ERB_CAN_RD = 6'h3E;
	// Preload image seed: word i holds i XOR this value
	localparam logic [ERB_DW_MAX-1:0] ERB_INIT_IMG = 72'h0;

	// APB register map
	localparam int ERB_PADDR_W = 8;
	localparam int ERB_PDATA_W = 32;
	localparam logic [ERB_PADDR_W-1:0] ERB_CFG0_OFS = 8'h00;
	localparam logic [ERB_PADDR_W-1:0] ERB_MODE_OFS = 8'h18;
	localparam logic [ERB_PADDR_W-1:0] ERB_STAT_OFS = 8'h1C;
	localparam logic [ERB_PADDR_W-1:0] ERB_MAP_END = 8'h20;
	localparam int ERB_IDX_LO = 2;
	localparam int ERB_IDX_W = 3;

	// Per-slot configuration fields: clock choice per register kind, then output bypass
	localparam int ERB_CF_CTL = 0;
	localparam int ERB_CF_ADDR = 1;
	localparam int ERB_CF_BE = 2;
	localparam int ERB_CF_DIN = 3;
	localparam int ERB_CF_OUT = 4;
	localparam int ERB_CF_BYP = 5;
	localparam int ERB_CFG_W = 6;
	localparam logic [ERB_CFG_W-1:0] ERB_CFG_RST = 6'h00;
	localparam logic [ERB_NBLK-1:0] ERB_MODE_RST = 3'h0;
	// Status fields
	localparam int ERB_ST_OV = 0;
	localparam int ERB_ST_RR = 8;

	typedef struct packed {
		logic clken;
		logic wren;
		logic rden;
		logic addr_ena;
		logic aclr;
		logic [ERB_AW_MAX-1:0] addr;
		logic [ERB_BE_MAX-1:0] be;
		logic [ERB_DW_MAX-1:0] din;
	} erb_req_t;
endpackage

// *** core/erb_mem.sv ***
/*
 * Dual-port storage array with byte-lane writes and registered read data.
 * Assumes the caller has already registered every input and gives one-cycle
 * access strobes; both ports run on the one system clock.
 */
`timescale 1ns/100ps
module erb_mem #(
	parameter int AW = 5,
	parameter int BW = 2,
	parameter bit INIT_EN = 1'b1,
	parameter logic [erb_pkg::ERB_DW_MAX-1:0] INIT_IMG = '0
) (
	input wire logic clk, // System clock
	input wire logic nrst, // Async reset, low
	input wire logic a_we, // Port A write strobe
	input wire logic a_re, // Port A read strobe
	input wire logic [AW-1:0] a_addr, // Port A address
	input wire logic [BW-1:0] a_be, // Port A byte enables
	input wire logic [BW*erb_pkg::ERB_BYTE_W-1:0] a_din, // Port A write data
	output logic [BW*erb_pkg::ERB_BYTE_W-1:0] a_q, // Port A read data
	input wire logic b_we, // Port B write strobe
	input wire logic b_re, // Port B read strobe
	input wire logic [AW-1:0] b_addr, // Port B address
	input wire logic [BW-1:0] b_be, // Port B byte enables
	input wire logic [BW*erb_pkg::ERB_BYTE_W-1:0] b_din, // Port B write data
	output logic [BW*erb_pkg::ERB_BYTE_W-1:0] b_q // Port B read data
);
	import erb_pkg::*;
	localparam int DW = BW * ERB_BYTE_W;
	localparam int DEPTH = 1 << AW;

	logic [DW-1:0] mem [DEPTH];

	////////////////////////////////////////////////////////////////////////
	// Preload image; without it the array stays undefined until written
	initial begin
		if (INIT_EN) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] = DW'(i) ^ INIT_IMG[DW-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Same-address writes from both ports: B lands last and wins on shared lanes
	always_ff @(posedge clk) begin
		for (int k = 0; k < BW; k++) begin
			if (a_we && a_be[k]) begin
				mem[a_addr][k*ERB_BYTE_W +: ERB_BYTE_W] <= a_din[k*ERB_BYTE_W +: ERB_BYTE_W];
			end
			if (b_we && b_be[k]) begin
				mem[b_addr][k*ERB_BYTE_W +: ERB_BYTE_W] <= b_din[k*ERB_BYTE_W +: ERB_BYTE_W];
			end
		end
	end

	// Read returns old data when the other port writes the same word
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			a_q <= '0;
		end else if (a_re) begin
			a_q <= mem[a_addr];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			b_q <= '0;
		end else if (b_re) begin
			b_q <= mem[b_addr];
		end
	end
endmodule

// *** tb/erb_top_assertions.sv ***
/*
 * Port-level checker for the embedded RAM block set, bound into erb_top.
 * Assumes one clock, active-low async reset and the APB map of erb_pkg.
 */
`timescale 1ns/100ps
module erb_top_assertions (
	input wire logic clk, // System clock
	input wire logic nrst, // Async reset, low
	input wire logic [erb_pkg::ERB_NBLK-1:0] blk_tick0, // First tick
	input wire logic [erb_pkg::ERB_NBLK-1:0] blk_tick1, // Second tick
	input wire erb_pkg::erb_req_t [erb_pkg::ERB_NSLOT-1:0] port_req, // Requests
	input wire logic [erb_pkg::ERB_NSLOT-1:0][erb_pkg::ERB_DW_MAX-1:0] port_dout, // Data
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [erb_pkg::ERB_PADDR_W-1:0] paddr, // APB address
	input wire logic [erb_pkg::ERB_PDATA_W-1:0] pwdata, // APB write data
	input wire logic [erb_pkg::ERB_PDATA_W-1:0] prdata, // APB read data
	input wire logic pready, // APB ready
	input wire logic pslverr // APB error
);
	import erb_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	////////////////////////////////////////////////////////////
	// Bypass of medium port A, shadowed from APB writes
	logic byp2_r;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) byp2_r <= 1'b0;
		else if (psel && penable && pwrite && paddr == 8'h08) byp2_r <= pwdata[5];
	end
	////////////////////////////////////////////////////////////
	a_ready_high: assert property (pready) else $error("pready low");
	a_err_decode: assert property (pslverr == (psel && penable &&
		(paddr >= ERB_MAP_END || paddr[1:0] != 2'h0))) else $error("pslverr decode wrong");
	a_err_zero_data: assert property (pslverr && !pwrite |-> prdata == '0)
		else $error("refused read data not zero");
	a_rdata_hold: assert property (psel && penable ##1 !psel |-> $stable(prdata))
		else $error("prdata moved while idle");
	a_wo_slot_zero: assert property (port_dout[0] == '0) else $error("write slot shows data");
	// Unless cleared, port A output may only move one or two cycles after a tick of its block
	a_med_quiet: assert property (!port_req[2].aclr && !$past(port_req[2].aclr) &&
		!$past(blk_tick0[1] || blk_tick1[1]) && !$past(blk_tick0[1] || blk_tick1[1], 2)
		|-> $stable(port_dout[2])) else $error("medium output moved untimed");
	a_large_quiet: assert property (!port_req[4].aclr && !$past(port_req[4].aclr) &&
		!$past(blk_tick0[2] || blk_tick1[2]) && !$past(blk_tick0[2] || blk_tick1[2], 2)
		|-> $stable(port_dout[4])) else $error("large output moved untimed");
	a_clear_output: assert property (port_req[2].aclr && !byp2_r |-> port_dout[2] == '0)
		else $error("cleared output not zero");
endmodule
bind erb_top erb_top_assertions u_erb_top_assertions (.clk, .nrst, .blk_tick0, .blk_tick1,
	.port_req, .port_dout, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
	.pslverr);

// *** tb/erb_user_model.sv ***
/*
 * User logic beside the RAM blocks: drives port requests and clock ticks.
 * Assumes the caller invokes its tasks from a clocked sequence on clk.
 */
`timescale 1ns/100ps
module erb_user_model (
	input wire logic clk, // System clock
	output erb_pkg::erb_req_t [erb_pkg::ERB_NSLOT-1:0] port_req, // Requests
	output logic [erb_pkg::ERB_NBLK-1:0] blk_tick0, // First tick
	output logic [erb_pkg::ERB_NBLK-1:0] blk_tick1 // Second tick
);
	import erb_pkg::*;
	initial begin
		port_req = '0;
		blk_tick0 = '0;
		blk_tick1 = '0;
	end
	task automatic tick(input int b, input bit sel);
		if (sel) blk_tick1[b] <= 1'b1;
		else blk_tick0[b] <= 1'b1;
	endtask
	// Control tick, array edge, then output tick; leaves data registered
	task automatic access(input int s, input bit w, input logic [12:0] a,
		input logic [7:0] be, input logic [71:0] d, input bit sel);
		repeat ($urandom % 3) @(posedge clk);
		@(posedge clk);
		port_req[s] <= '{1'b1, w, !w, 1'b1, port_req[s].aclr, a, be, d};
		tick(s / 2, sel);
		@(posedge clk);
		// Released lines do not keep the last value
		port_req[s] <= '{1'b0, !w, w, 1'b0, port_req[s].aclr, ~a, ~be, ~d};
		blk_tick0 <= '0;
		blk_tick1 <= '0;
		@(posedge clk);
		tick(s / 2, sel);
		@(posedge clk);
		blk_tick0 <= '0;
		blk_tick1 <= '0;
	endtask
	task automatic clr(input int s, input bit v);
		@(posedge clk);
		port_req[s].aclr <= v;
	endtask
endmodule

// *** tb/erb_top_tb.sv ***
/*
 * Self-checking bench for erb_top: APB master, user-logic model, memory model.
 * Assumes the bound checker and a 10 MHz clock.
 */
`timescale 1ns/100ps
module erb_top_tb;
	import erb_pkg::*;
	logic clk, nrst, psel, penable, pwrite, pready, pslverr, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [2:0] rom;
	erb_req_t [ERB_NSLOT-1:0] port_req;
	logic [ERB_NBLK-1:0] blk_tick0, blk_tick1;
	logic [ERB_NSLOT-1:0][ERB_DW_MAX-1:0] port_dout;
	logic [71:0] mem [int];
	int miscompares, comparisons, cycles, s, w;
	erb_top u_erb_top (.clk, .nrst, .blk_tick0, .blk_tick1, .port_req, .port_dout, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
	erb_user_model u_erb_user_model (.clk, .port_req, .blk_tick0, .blk_tick1);
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			report_and_stop();
		end
	end
	////////////////////////////////////////////////////////////
	task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t register %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk72(input logic [71:0] got, input logic [71:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t port data %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
		apb(1'b0, a, 32'h0);
		chk32(q, exp);
		chk32({31'h0, e}, {31'h0, err});
	endtask
	function automatic logic [71:0] peek(input int s, input logic [12:0] a);
		int k = s / 2 * 8192 + a;
		return mem.exists(k) ? mem[k] : {59'h0, a};
	endfunction
	// One port access; reads are compared with the model
	task automatic op(input int s, input bit w, input logic [12:0] a, input bit sel);
		logic [71:0] d, old;
		logic [7:0] be;
		int b;
		b = s / 2;
		d = 72'({$urandom, $urandom, $urandom});
		be = 8'($urandom);
		old = peek(s, a);
		// Large array starts undefined: its first write covers every lane
		if (w && b == 2 && !mem.exists(b * 8192 + a)) be = 8'hFF;
		u_erb_user_model.access(s, w, a, be, d, sel);
		@(negedge clk);
		if (w) begin
			for (int k = 0; k < ERB_BE[b]; k++) if (be[k]) old[9*k+:9] = d[9*k+:9];
			if (!rom[b]) mem[b * 8192 + a] = old;
		end else chk72(port_dout[s], old);
	endtask
	task automatic done(input string name);
		$display("test %s finished", name);
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		{nrst, psel, penable, pwrite, paddr, pwdata, rom} = '0;
		void'($urandom(32'hf987da0e));
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		for (int i = 0; i < 8; i++) rd(8'(4 * i), 32'h0, 1'b0);
		rd(8'h20, 32'h0, 1'b1);
		rd(8'h02, 32'h0, 1'b1);
		apb(1'b1, 8'h10, 32'h1F);
		rd(8'h10, 32'h1F, 1'b0);
		apb(1'b1, 8'h18, 32'h7);
		rd(8'h18, 32'h3, 1'b0);
		apb(1'b1, 8'h18, 32'h0);
		done("registers");
		for (int i = 0; i < 4; i++) begin
			op(1, 0, 13'(i * 10), 0);
			op(2, 0, 13'(i * 40), 0);
		end
		op(4, 1, 13'h1FFF, 1);
		op(5, 0, 13'h1FFF, 0);
		op(3, 1, 13'h7F, 0);
		op(2, 0, 13'h7F, 0);
		done("preload");
		repeat (40) begin
			s = $urandom % 6;
			w = s == 0 || (s != 1 && $urandom % 2);
			if (s >= 4 && !mem.exists(s / 2 * 8192 + 5)) w = 1;
			op(s, w, 13'h5, s == 4);
		end
		done("random");
		apb(1'b1, 8'h18, 32'h2);
		rom = 3'h2;
		op(2, 1, 13'h5, 0);
		op(3, 0, 13'h5, 0);
		rd(8'h1C, 32'h200 | {26'h0, 6'h3F}, 1'b0);
		apb(1'b1, 8'h1C, 32'h200);
		rd(8'h1C, {26'h0, 6'h3F}, 1'b0);
		apb(1'b1, 8'h18, 32'h0);
		rom = 3'h0;
		done("rom lock");
		apb(1'b1, 8'h0C, 32'h20);
		op(3, 0, 13'h5, 0);
		u_erb_user_model.clr(3, 1);
		@(negedge clk);
		chk72(port_dout[3], peek(3, 13'h5));
		op(2, 0, 13'h5, 0);
		u_erb_user_model.clr(2, 1);
		@(negedge clk);
		chk72(port_dout[2], 72'h0);
		u_erb_user_model.clr(2, 0);
		u_erb_user_model.clr(3, 0);
		op(2, 0, 13'h5, 0);
		done("clear");
		report_and_stop();
	end
endmodule
